/* File: hdl/misc_regs_pkg.sv */
// misc_regs_pkg: offsets, field positions, reset values and types of the
// identity, byte order and hardware configuration registers.
// assumes a single system clock domain at 50 MHz.
package misc_regs_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [9:0] OFS_IDENTITY = 10'h050;
  localparam logic [9:0] OFS_BYTE_ORDER = 10'h064;
  localparam logic [9:0] OFS_HW_CONFIG = 10'h074;

  // ==========================================================
  // field positions in the hardware configuration word
  localparam int READY_BIT = 27;
  localparam int XOVER2_BIT = 26;
  localparam int XOVER1_BIT = 25;

  // ==========================================================
  // constant values
  localparam logic [31:0] BYTE_ORDER_VALUE = 32'h8765_4321;
  localparam logic [31:0] RESET_READ_VALUE = 32'h0000_0000;
  localparam logic [15:0] IDENTITY_DEFAULT = 16'h0a5c; // arbitrary value, names no real part
  localparam logic [15:0] REVISION_DEFAULT = 16'h0001; // arbitrary value

  // ==========================================================
  // timing: settle time before the ready flag rises
  localparam int SETTLE_NS = 1000;
  localparam int CLK_NS = 20;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    HALF_BOTH,
    HALF_LOW,
    HALF_HIGH
  } half_sel_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [9:0] addr;
    half_sel_t half;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    logic override_en;
    logic override_val;
  } xover_override_t;

endpackage

/* File: hdl/misc_system_id_config_regs.sv */
// misc_system_id_config_regs: identity, byte order and hardware
// configuration registers as read by the serial management slave.
// assumes requests come from management logic on clk_sys; straps are pins.
// Notes on behaviour
// RL1: fixed identity code in upper half
// RL2: revision value in lower half
// RL3: byte order register returns constant pattern
// RL4: byte order readable while not ready
// RL5: reads during reset never show pattern
// RL6: either half readable alone in extended mode
// RL7: config register pollable in reset, invalid then
// RL8: ready flag cleared by reset, set when settled
// RL9: ready rise can raise enabled interrupt
// RL10: host reads only permitted registers while not ready
// RL11: writes before ready are invalid, ignored
// RL12: port 2 crossover strap latched, loader rewritable
// RL13: port 1 crossover strap latched, loader rewritable
// RL14: per-port override replaces latched strap
// RL15: reserved config bits read zero
// RL16: writes to read-only registers ignored silently
`timescale 1ns/1ns

module misc_system_id_config_regs #(
  parameter logic [15:0] IDENTITY_CODE = misc_regs_pkg::IDENTITY_DEFAULT, // arbitrary
  parameter logic [15:0] REVISION_CODE = misc_regs_pkg::REVISION_DEFAULT // arbitrary
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register access
  input wire misc_regs_pkg::reg_req_t req,
  output misc_regs_pkg::reg_rsp_t rsp,
  // straps and loader
  input wire logic strap_xover1,
  input wire logic strap_xover2,
  input wire logic loader_we,
  input wire logic loader_xover1,
  input wire logic loader_xover2,
  // per-port overrides from the phy special control registers
  input wire misc_regs_pkg::xover_override_t override1,
  input wire misc_regs_pkg::xover_override_t override2,
  // status and interrupt
  input wire logic ready_irq_en,
  output logic device_ready,
  output logic ready_irq,
  output logic xover1_eff,
  output logic xover2_eff
);

  // ==========================================================
  // strap synchronisers; first stage read only by the second
  logic [1:0] strap_s1_r;
  logic [1:0] strap_s2_r;
  always_ff @(posedge clk_sys) begin
    strap_s1_r <= {strap_xover2, strap_xover1};
    strap_s2_r <= strap_s1_r;
  end

  // ==========================================================
  // settle counter and ready flag
  logic [15:0] settle_r;
  logic [15:0] settle_nxt;
  logic ready_r;
  wire settle_done = (settle_r == 16'(misc_regs_pkg::SETTLE_CYCLES));
  assign settle_nxt = settle_done ? settle_r : settle_r + 16'h0001;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      settle_r <= 16'h0000;
      ready_r <= 1'b0; // RL8
    end else begin
      settle_r <= settle_nxt;
      ready_r <= settle_done; // RL8
    end
  end

  // ==========================================================
  // settle and ready checks
  // counter saturates, so ready cannot drop again without a reset
  settle_count_a: assert property (@(posedge clk_sys) disable iff (srst) // RL8
    settle_r <= 16'(misc_regs_pkg::SETTLE_CYCLES))
    else $error("settle counter overran");

  settle_step_a: assert property (@(posedge clk_sys) disable iff (srst) // RL8
    !settle_done |=> settle_r == $past(settle_r) + 16'h0001)
    else $error("settle counter skipped");

  ready_hold_a: assert property (@(posedge clk_sys) disable iff (srst) // RL8
    ready_r |=> ready_r)
    else $error("ready dropped without reset");

  ready_out_a: assert property (@(posedge clk_sys) disable iff (srst) // RL8
    !$past(srst) |-> device_ready == $past(ready_r))
    else $error("ready output does not follow flag");

  irq_once_a: assert property (@(posedge clk_sys) disable iff (srst) // RL9
    ready_irq |=> !ready_irq)
    else $error("ready interrupt longer than a cycle");

  irq_cause_a: assert property (@(posedge clk_sys) disable iff (srst) // RL9
    $rose(ready_r) && $past(ready_irq_en) |-> ready_irq)
    else $error("enabled ready interrupt missing");

  // ==========================================================
  // crossover strap latches: track the pins during reset, hold after unless the loader writes
  logic xover1_r;
  logic xover2_r;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      xover1_r <= strap_s2_r[0]; // RL13
      xover2_r <= strap_s2_r[1]; // RL12
    end else if (loader_we) begin
      xover1_r <= loader_xover1; // RL13
      xover2_r <= loader_xover2; // RL12
    end
  end

  wire xover1_nxt = override1.override_en ? override1.override_val : xover1_r; // RL14
  wire xover2_nxt = override2.override_en ? override2.override_val : xover2_r; // RL14

  // ==========================================================
  // strap latch checks
  // the latch takes the synchronised pin; the raw pin may move mid-cycle
  strap_track_a: assert property (@(posedge clk_sys) // RL12 RL13
    srst && $past(srst, 2) |=>
      xover1_r == $past(strap_s2_r[0]) && xover2_r == $past(strap_s2_r[1]))
    else $error("strap latch missed pin level in reset");

  loader_write_a: assert property (@(posedge clk_sys) disable iff (srst) // RL12 RL13
    loader_we |=> xover1_r == $past(loader_xover1) && xover2_r == $past(loader_xover2))
    else $error("loader value not stored");

  port2_override_a: assert property (@(posedge clk_sys) disable iff (srst) // RL14
    override2.override_en |=> xover2_eff == $past(override2.override_val))
    else $error("port 2 override ignored");

  port1_latch_a: assert property (@(posedge clk_sys) disable iff (srst) // RL13 RL14
    !override1.override_en |=> xover1_eff == $past(xover1_r))
    else $error("port 1 latch not passed through");

  port2_latch_a: assert property (@(posedge clk_sys) disable iff (srst) // RL12 RL14
    !override2.override_en |=> xover2_eff == $past(xover2_r))
    else $error("port 2 latch not passed through");

  // ==========================================================
  // read decode
  function automatic logic [31:0] half_mask(input misc_regs_pkg::half_sel_t h);
    case (h)
      misc_regs_pkg::HALF_LOW: half_mask = 32'h0000_ffff;
      misc_regs_pkg::HALF_HIGH: half_mask = 32'hffff_0000;
      default: half_mask = 32'hffff_ffff;
    endcase
  endfunction

  wire [31:0] ident_word = {IDENTITY_CODE, REVISION_CODE}; // RL1 RL2
  logic [31:0] cfg_word;
  always_comb begin
    cfg_word = 32'h0000_0000; // RL15
    cfg_word[misc_regs_pkg::READY_BIT] = ready_r;
    cfg_word[misc_regs_pkg::XOVER2_BIT] = xover2_r; // RL12
    cfg_word[misc_regs_pkg::XOVER1_BIT] = xover1_r; // RL13
  end

  wire hit_ident = (req.addr == misc_regs_pkg::OFS_IDENTITY);
  wire hit_byte = (req.addr == misc_regs_pkg::OFS_BYTE_ORDER);
  wire hit_cfg = (req.addr == misc_regs_pkg::OFS_HW_CONFIG);
  // while not ready only the pollable registers answer with content
  wire allowed = ready_r | hit_byte | hit_cfg; // RL4 RL10
  wire [31:0] sel_word =
    hit_byte ? misc_regs_pkg::BYTE_ORDER_VALUE : // RL3
    hit_cfg ? cfg_word :
    (hit_ident && allowed) ? ident_word : 32'h0000_0000;
  // half select applies to every register; harmless for identity
  wire [31:0] rd_word = sel_word & half_mask(req.half); // RL6

  // ==========================================================
  // response; writes store nothing, so they are silently dropped
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsp <= '0; // RL5 RL7
      device_ready <= 1'b0;
      ready_irq <= 1'b0;
      xover1_eff <= 1'b0;
      xover2_eff <= 1'b0;
    end else begin
      rsp.valid <= req.valid; // RL11 RL16
      rsp.rdata <= (req.valid && !req.write) ? rd_word : misc_regs_pkg::RESET_READ_VALUE;
      device_ready <= ready_r;
      ready_irq <= ready_irq_en & settle_done & ~ready_r; // RL9
      xover1_eff <= xover1_nxt;
      xover2_eff <= xover2_nxt;
    end
  end

  // ==========================================================
  // response checks
  // idle cycles answer zero, so a late sampler never sees stale data
  sequence byte_low_read_s;
    req.valid && !req.write && hit_byte && req.half == misc_regs_pkg::HALF_LOW;
  endsequence
  sequence byte_high_read_s;
    req.valid && !req.write && hit_byte && req.half == misc_regs_pkg::HALF_HIGH;
  endsequence
  sequence cfg_upper_read_s;
    req.valid && !req.write && hit_cfg && req.half != misc_regs_pkg::HALF_LOW;
  endsequence

  rsp_valid_a: assert property (@(posedge clk_sys) disable iff (srst) // RL4
    req.valid |=> rsp.valid)
    else $error("request not answered");

  rsp_idle_a: assert property (@(posedge clk_sys) disable iff (srst) // RL16
    !req.valid |=> !rsp.valid && rsp.rdata == misc_regs_pkg::RESET_READ_VALUE)
    else $error("answer without request");

  reset_quiet_a: assert property (@(posedge clk_sys) // RL5 RL7
    srst |=> !rsp.valid && rsp.rdata == misc_regs_pkg::RESET_READ_VALUE
      && !device_ready && !ready_irq)
    else $error("outputs active in reset");

  byte_low_a: assert property (@(posedge clk_sys) disable iff (srst) // RL6
    byte_low_read_s |=> rsp.rdata == {16'h0000, misc_regs_pkg::BYTE_ORDER_VALUE[15:0]})
    else $error("low half of byte order pattern wrong");

  byte_high_a: assert property (@(posedge clk_sys) disable iff (srst) // RL6
    byte_high_read_s |=> rsp.rdata == {misc_regs_pkg::BYTE_ORDER_VALUE[31:16], 16'h0000})
    else $error("high half of byte order pattern wrong");

  half_high_a: assert property (@(posedge clk_sys) disable iff (srst) // RL6
    (req.valid && !req.write && req.half == misc_regs_pkg::HALF_HIGH)
    |=> rsp.rdata[15:0] == 16'h0000)
    else $error("lower half leaked in high read");

  cfg_ready_a: assert property (@(posedge clk_sys) disable iff (srst) // RL8
    cfg_upper_read_s |=> rsp.rdata[misc_regs_pkg::READY_BIT] == $past(ready_r))
    else $error("ready bit misreported");

  cfg_strap_a: assert property (@(posedge clk_sys) disable iff (srst) // RL12 RL13
    cfg_upper_read_s |=> rsp.rdata[misc_regs_pkg::XOVER2_BIT] == $past(xover2_r)
      && rsp.rdata[misc_regs_pkg::XOVER1_BIT] == $past(xover1_r))
    else $error("strap bits misreported");

  ident_high_a: assert property (@(posedge clk_sys) disable iff (srst) // RL1
    (req.valid && !req.write && hit_ident && ready_r && req.half == misc_regs_pkg::HALF_HIGH)
    |=> rsp.rdata == {IDENTITY_CODE, 16'h0000})
    else $error("identity code half wrong");

  rev_low_a: assert property (@(posedge clk_sys) disable iff (srst) // RL2
    (req.valid && !req.write && hit_ident && ready_r && req.half == misc_regs_pkg::HALF_LOW)
    |=> rsp.rdata == {16'h0000, REVISION_CODE})
    else $error("revision half wrong");

  unmapped_zero_a: assert property (@(posedge clk_sys) disable iff (srst) // RL15
    (req.valid && !req.write && !hit_ident && !hit_byte && !hit_cfg)
    |=> rsp.rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  // ==========================================================
  // assertions
  byte_in_reset_a: assert property (@(posedge clk_sys) // RL5 RL7
    $past(srst) |-> rsp.rdata != misc_regs_pkg::BYTE_ORDER_VALUE)
    else $error("pattern visible right after reset");

  sequence byte_full_read_s;
    req.valid && !req.write && hit_byte && req.half == misc_regs_pkg::HALF_BOTH;
  endsequence
  byte_pattern_a: assert property (@(posedge clk_sys) disable iff (srst) // RL3
    byte_full_read_s |=> rsp.rdata == misc_regs_pkg::BYTE_ORDER_VALUE)
    else $error("byte order pattern wrong");

  ident_read_a: assert property (@(posedge clk_sys) disable iff (srst) // RL1
    (req.valid && !req.write && hit_ident && ready_r && req.half == misc_regs_pkg::HALF_BOTH)
    |=> rsp.rdata == {IDENTITY_CODE, REVISION_CODE})
    else $error("identity word wrong");

  half_low_a: assert property (@(posedge clk_sys) disable iff (srst) // RL6
    (req.valid && !req.write && req.half == misc_regs_pkg::HALF_LOW)
    |=> rsp.rdata[31:16] == 16'h0000)
    else $error("upper half leaked in low read");

  ready_low_a: assert property (@(posedge clk_sys) // RL8
    srst |=> !ready_r [*2])
    else $error("ready not cleared by reset");

  ready_rise_a: assert property (@(posedge clk_sys) disable iff (srst) // RL8
    $rose(ready_r) |-> settle_r == 16'(misc_regs_pkg::SETTLE_CYCLES))
    else $error("ready rose early");

  irq_pulse_a: assert property (@(posedge clk_sys) disable iff (srst) // RL9
    ready_irq |-> ready_r && !$past(ready_r, 2) && $past(ready_irq_en))
    else $error("ready interrupt without cause");

  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (srst) // RL15
    (req.valid && !req.write && hit_cfg) |=> (rsp.rdata & 32'hf1ff_ffff) == 32'h0000_0000)
    else $error("reserved config bits set");

  strap_hold_a: assert property (@(posedge clk_sys) disable iff (srst) // RL12 RL13
    !loader_we |=> $stable(xover1_r) && $stable(xover2_r))
    else $error("strap latch changed without loader");

  override_a: assert property (@(posedge clk_sys) disable iff (srst) // RL14
    override1.override_en |=> xover1_eff == $past(override1.override_val))
    else $error("override ignored");

  write_data_a: assert property (@(posedge clk_sys) disable iff (srst) // RL11 RL16
    (req.valid && req.write) |=> rsp.rdata == misc_regs_pkg::RESET_READ_VALUE)
    else $error("write returned data");

endmodule // misc_system_id_config_regs

/* File: tb/host_model.sv */
// host_model: management host that issues register requests to the block.
// assumes the answer comes one clk_sys cycle after the request edge.
`timescale 1ns/1ns
module host_model (
  // clock
  input wire logic clk_sys,
  // register access
  output misc_regs_pkg::reg_req_t req,
  input wire misc_regs_pkg::reg_rsp_t rsp
);
  initial req = '0;
  // ============================================================
  // one request, held until the taking edge, answer read 1 ns after that same edge
  task automatic xfer(input logic wr, input logic [9:0] a, input misc_regs_pkg::half_sel_t h,
      output logic v, output logic [31:0] d);
    @(posedge clk_sys);
    #1;
    req = '{valid: 1'b1, write: wr, addr: a, half: h, wdata: 32'hffff_ffff};
    @(posedge clk_sys);
    #1;
    v = rsp.valid;
    d = rsp.rdata;
    // released address flips so a stale decode cannot pass
    req = '{valid: 1'b0, write: ~wr, addr: ~a, half: h, wdata: 32'h0000_0000};
  endtask
endmodule // host_model

/* File: tb/misc_system_id_config_regs_tb_top.sv */
// testbench for the identity, byte order and hardware configuration registers.
// assumes host_model drives the request port; straps and loader driven here.
`timescale 1ns/1ns
module misc_system_id_config_regs_tb_top;
  localparam logic [9:0] A_ID = misc_regs_pkg::OFS_IDENTITY;
  localparam logic [9:0] A_BO = misc_regs_pkg::OFS_BYTE_ORDER;
  localparam logic [9:0] A_HW = misc_regs_pkg::OFS_HW_CONFIG;
  localparam logic [31:0] PAT = misc_regs_pkg::BYTE_ORDER_VALUE;
  logic clk_sys, srst, strap_xover1, strap_xover2, loader_we, loader_xover1, loader_xover2;
  logic ready_irq_en, device_ready, ready_irq, xover1_eff, xover2_eff, v;
  logic [31:0] d;
  misc_regs_pkg::reg_req_t req;
  misc_regs_pkg::reg_rsp_t rsp;
  misc_regs_pkg::xover_override_t override1, override2;
  int err_count = 0;
  int tests_run = 0;
  int irq_seen = 0;

  misc_system_id_config_regs DUT (.clk_sys(clk_sys), .srst(srst), .req(req), .rsp(rsp),
    .strap_xover1(strap_xover1), .strap_xover2(strap_xover2), .loader_we(loader_we),
    .loader_xover1(loader_xover1), .loader_xover2(loader_xover2), .override1(override1),
    .override2(override2), .ready_irq_en(ready_irq_en), .device_ready(device_ready),
    .ready_irq(ready_irq), .xover1_eff(xover1_eff), .xover2_eff(xover2_eff));
  host_model host (.clk_sys(clk_sys), .req(req), .rsp(rsp));

  // ============================================================
  // clock, interrupt counter, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (ready_irq === 1'b1) irq_seen++;
  // the whole sequence takes about 140 cycles; allow over ten times that
  initial begin
    #30000;
    err_count++;
    complete_run();
  end

  // ============================================================
  // compare, access and closing tasks
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ne(input logic [31:0] got, input logic [31:0] bad);
    tests_run++;
    if (got === bad) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=not %h", $time, got, bad);
    end
  endtask
  task automatic rd(input logic [9:0] a, input misc_regs_pkg::half_sel_t h, input logic [31:0] e);
    host.xfer(1'b0, a, h, v, d);
    chk32({31'h0, v}, 32'h1);
    chk32(d, e);
  endtask
  task automatic wr(input logic [9:0] a);
    host.xfer(1'b1, a, misc_regs_pkg::HALF_BOTH, v, d);
    chk32({31'h0, v}, 32'h1);
    chk32(d, 32'h0);
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 100 && device_ready !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ============================================================
  // tests
  initial begin
    srst = 1'b1;
    strap_xover1 = 1'b1;
    strap_xover2 = 1'b0;
    {loader_we, loader_xover1, loader_xover2} = 3'h0;
    override1 = '0;
    override2 = '0;
    ready_irq_en = 1'b1;
    repeat (10) @(posedge clk_sys);
    // polling in reset takes the last two reset edges
    host.xfer(1'b0, A_BO, misc_regs_pkg::HALF_BOTH, v, d);
    chk_ne(d, PAT);
    srst = 1'b0;
    $display("test reset_poll done");
    rd(A_BO, misc_regs_pkg::HALF_BOTH, PAT);
    rd(A_BO, misc_regs_pkg::HALF_LOW, 32'h0000_4321);
    rd(A_BO, misc_regs_pkg::HALF_HIGH, 32'h8765_0000);
    rd(A_HW, misc_regs_pkg::HALF_BOTH, 32'h0200_0000);
    rd(A_HW, misc_regs_pkg::HALF_LOW, 32'h0000_0000);
    wr(A_BO);
    rd(A_BO, misc_regs_pkg::HALF_BOTH, PAT);
    $display("test not_ready done");
    wait_ready();
    chk32({31'h0, device_ready}, 32'h1);
    chk32(32'(irq_seen), 32'h1);
    rd(A_HW, misc_regs_pkg::HALF_HIGH, 32'h0a00_0000);
    rd(A_ID, misc_regs_pkg::HALF_BOTH,
      {misc_regs_pkg::IDENTITY_DEFAULT, misc_regs_pkg::REVISION_DEFAULT});
    rd(A_ID, misc_regs_pkg::HALF_LOW, {16'h0000, misc_regs_pkg::REVISION_DEFAULT});
    wr(A_ID);
    rd(A_ID, misc_regs_pkg::HALF_HIGH, {misc_regs_pkg::IDENTITY_DEFAULT, 16'h0000});
    rd(10'h058, misc_regs_pkg::HALF_BOTH, 32'h0000_0000);
    $display("test ready done");
    @(posedge clk_sys);
    #1;
    {loader_we, loader_xover1, loader_xover2} = 3'b101;
    @(posedge clk_sys);
    #1;
    loader_we = 1'b0;
    rd(A_HW, misc_regs_pkg::HALF_BOTH, 32'h0c00_0000);
    override1 = '{override_en: 1'b1, override_val: 1'b1};
    override2 = '{override_en: 1'b1, override_val: 1'b0};
    repeat (2) @(posedge clk_sys);
    #1;
    chk32({30'h0, xover2_eff, xover1_eff}, 32'h1);
    override1 = '0;
    override2 = '0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk32({30'h0, xover2_eff, xover1_eff}, 32'h2);
    $display("test crossover done");
    srst = 1'b1;
    ready_irq_en = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    chk32({31'h0, device_ready}, 32'h0);
    // straps latched afresh in reset, loader value gone, ready cleared
    rd(A_HW, misc_regs_pkg::HALF_BOTH, 32'h0200_0000);
    wait_ready();
    chk32({31'h0, device_ready}, 32'h1);
    chk32(32'(irq_seen), 32'h1);
    $display("test second_reset done");
    complete_run();
  end
endmodule // misc_system_id_config_regs_tb_top
